/* File: src/arw_pkg.sv */
// package: register map, field positions, reset values and route codes of the converter register block
package arw_pkg;
  // register indices as printed; 0xa is not a multiple of four, so byte address = 4 * index
  localparam logic [7:0] ARW_IDX_WD_UPPER_HIGH = 8'h0a;
  localparam logic [7:0] ARW_IDX_CTRL_THREE = 8'h8c;
  localparam logic [7:0] ARW_IDX_RESULT_UPPER = 8'h90;
  localparam logic [7:0] ARW_IDX_RESULT_LOWER = 8'h94;
  localparam logic [7:0] ARW_IDX_SCHMITT_UPPER = 8'h98;
  localparam logic [7:0] ARW_IDX_SCHMITT_LOWER = 8'h9c;
  localparam logic [7:0] ARW_IDX_WD_UPPER_LOW = 8'ha4;
  localparam logic [7:0] ARW_IDX_WD_LOWER_HIGH = 8'ha8;
  localparam logic [7:0] ARW_IDX_WD_LOWER_LOW = 8'hac;
  localparam logic [7:0] ARW_IDX_WD_FLAGS_UPPER = 8'hb0;
  // registers without documented offsets in this block (own choice)
  localparam logic [7:0] ARW_IDX_WD_FLAGS_LOWER = 8'hb4;
  localparam logic [7:0] ARW_IDX_WD_ENABLE_UPPER = 8'hb8;
  localparam logic [7:0] ARW_IDX_WD_ENABLE_LOWER = 8'hbc;
  localparam logic [7:0] ARW_IDX_MODE = 8'hc8;
  // field positions
  localparam int ARW_BIT_OVERRUN = 6;
  localparam int ARW_BIT_BUFFER_EN = 7;
  localparam int ARW_BIT_CONTINUOUS = 0;
  localparam int ARW_BIT_SCAN = 1;
  // reset values
  localparam logic [7:0] ARW_RST_WD_UPPER_HIGH = 8'hff;
  localparam logic [3:0] ARW_RST_WD_UPPER_LOW = 4'hf;
  localparam logic [7:0] ARW_RST_ZERO8 = 8'h00;
  localparam logic [3:0] ARW_RST_ZERO4 = 4'h0;
  localparam logic [1:0] ARW_RST_ZERO2 = 2'h0;
  // widths
  localparam int ARW_NCH = 10;
  // ahb transfer codes
  localparam logic [1:0] ARW_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] ARW_HTRANS_SEQ = 2'h3;
  // where a conversion result is routed
  typedef enum logic [2:0] {
    ARW_DEST_DIRECT = 3'h1,
    ARW_DEST_BUFFER = 3'h2,
    ARW_DEST_BOTH = 3'h4
  } arw_dest_t;
endpackage

/* File: src/arw_watchdog_cmp.sv */
// watchdog window compare for one 12-bit result
`timescale 1ns/1ps
module arw_watchdog_cmp (
  input wire logic [11:0] result,
  input wire logic [11:0] upper_limit,
  input wire logic [11:0] lower_limit,
  output logic outside
);
  // strict compare: a result equal to either limit is still inside the window
  assign outside = (result > upper_limit) || (result < lower_limit);
endmodule

/* File: src/arw_regs.sv */
// converter result, Schmitt disable and analog watchdog registers on an AHB-Lite slave
`timescale 1ns/1ps
module arw_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  input wire logic [3:0] conv_channel,
  input wire logic buffer_read,
  output logic buffer_write,
  output logic [3:0] buffer_channel,
  output logic [7:0] buffered_result_high,
  output logic [7:0] buffered_result_low,
  output logic [15:0] schmitt_disable_bits,
  output logic continuous_mode_select,
  output logic scan_mode
);

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture

  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] idx_r;
  logic [7:0] idx_nxt;
  logic take;

  // the slave never stalls, so every accepted transfer completes in one data cycle
  assign take = hsel && hready && (htrans == arw_pkg::ARW_HTRANS_NONSEQ ||
                htrans == arw_pkg::ARW_HTRANS_SEQ);
  // hsize is not decoded: only whole-word transfers are expected, narrower ones act as words
  assign idx_nxt = haddr[9:2];
  // no wait states and no error answer: every register access is a plain single cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // latch address phase; write data arrives next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite;
      rd_pend_r <= take && !hwrite;
      if (take) begin
        idx_r <= idx_nxt;
      end
    end
  end

  // one-hot write strobes in the data phase
  // a read issued right after a write to the same register still sees the old value
  logic w_ctrl;
  logic w_sch_u;
  logic w_sch_l;
  logic w_uh;
  logic w_ul;
  logic w_lh;
  logic w_ll;
  logic w_fu;
  logic w_fl;
  logic w_eu;
  logic w_el;
  logic w_mode;
  assign w_ctrl = wr_pend_r && idx_r == arw_pkg::ARW_IDX_CTRL_THREE;
  assign w_sch_u = wr_pend_r && idx_r == arw_pkg::ARW_IDX_SCHMITT_UPPER;
  assign w_sch_l = wr_pend_r && idx_r == arw_pkg::ARW_IDX_SCHMITT_LOWER;
  assign w_uh = wr_pend_r && idx_r == arw_pkg::ARW_IDX_WD_UPPER_HIGH;
  assign w_ul = wr_pend_r && idx_r == arw_pkg::ARW_IDX_WD_UPPER_LOW;
  assign w_lh = wr_pend_r && idx_r == arw_pkg::ARW_IDX_WD_LOWER_HIGH;
  assign w_ll = wr_pend_r && idx_r == arw_pkg::ARW_IDX_WD_LOWER_LOW;
  assign w_fu = wr_pend_r && idx_r == arw_pkg::ARW_IDX_WD_FLAGS_UPPER;
  assign w_fl = wr_pend_r && idx_r == arw_pkg::ARW_IDX_WD_FLAGS_LOWER;
  assign w_eu = wr_pend_r && idx_r == arw_pkg::ARW_IDX_WD_ENABLE_UPPER;
  assign w_el = wr_pend_r && idx_r == arw_pkg::ARW_IDX_WD_ENABLE_LOWER;
  assign w_mode = wr_pend_r && idx_r == arw_pkg::ARW_IDX_MODE;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic buffer_en_r;
  logic cont_r;
  logic scan_r;
  logic [7:0] sch_u_r;
  logic [7:0] sch_l_r;
  logic [7:0] uh_r;
  logic [3:0] ul_r;
  logic [7:0] lh_r;
  logic [3:0] ll_r;
  logic [1:0] en_u_r;
  logic [7:0] en_l_r;

  // plain read/write fields
  // writes land at the end of the data phase, the only cycle in which hwdata is valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buffer_en_r <= 1'b0;
      cont_r <= 1'b0;
      scan_r <= 1'b0;
      sch_u_r <= arw_pkg::ARW_RST_ZERO8;
      sch_l_r <= arw_pkg::ARW_RST_ZERO8;
      uh_r <= arw_pkg::ARW_RST_WD_UPPER_HIGH;
      ul_r <= arw_pkg::ARW_RST_WD_UPPER_LOW;
      lh_r <= arw_pkg::ARW_RST_ZERO8;
      ll_r <= arw_pkg::ARW_RST_ZERO4;
      en_u_r <= arw_pkg::ARW_RST_ZERO2;
      en_l_r <= arw_pkg::ARW_RST_ZERO8;
    end else begin
      if (w_ctrl) begin
        buffer_en_r <= hwdata[arw_pkg::ARW_BIT_BUFFER_EN];
      end
      if (w_mode) begin
        cont_r <= hwdata[arw_pkg::ARW_BIT_CONTINUOUS];
        scan_r <= hwdata[arw_pkg::ARW_BIT_SCAN];
      end
      if (w_sch_u) begin
        sch_u_r <= hwdata[7:0];
      end
      if (w_sch_l) begin
        sch_l_r <= hwdata[7:0];
      end
      if (w_uh) begin
        uh_r <= hwdata[7:0];
      end
      if (w_ul) begin
        ul_r <= hwdata[3:0];
      end
      if (w_lh) begin
        lh_r <= hwdata[7:0];
      end
      if (w_ll) begin
        ll_r <= hwdata[3:0];
      end
      if (w_eu) begin
        en_u_r <= hwdata[1:0];
      end
      if (w_el) begin
        en_l_r <= hwdata[7:0];
      end
    end
  end

  // 1 on a pin disables its Schmitt trigger
  assign schmitt_disable_bits = {sch_u_r, sch_l_r};
  assign continuous_mode_select = cont_r;
  assign scan_mode = scan_r;

  ////////////////////////////////////////////////////////////////////////
  // result routing

  arw_pkg::arw_dest_t dest;
  logic buffered;

  // buffered only in continuous mode with buffer enabled; single mode always goes direct
  // scan with buffering still goes to the buffer; the mirrored route code is left unused
  assign buffered = buffer_en_r && cont_r;
  always_comb begin
    case ({buffered, scan_r})
      2'b10: dest = arw_pkg::ARW_DEST_BUFFER;
      2'b11: dest = arw_pkg::ARW_DEST_BUFFER;
      default: dest = arw_pkg::ARW_DEST_DIRECT;
    endcase
  end

  logic [7:0] res_hi_r;
  logic [7:0] res_lo_r;
  logic unread_r;
  logic rd_data;

  // reading the lower part consumes the result
  assign rd_data = rd_pend_r && idx_r == arw_pkg::ARW_IDX_RESULT_LOWER;

  // direct result registers, valid in single or non-buffered operation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_hi_r <= arw_pkg::ARW_RST_ZERO8;
      res_lo_r <= arw_pkg::ARW_RST_ZERO8;
    end else if (conv_done && dest == arw_pkg::ARW_DEST_DIRECT) begin
      res_hi_r <= {4'h0, conv_result[11:8]};
      res_lo_r <= conv_result[7:0];
    end
  end

  // buffered path outputs toward the per-channel store
  // the store itself lives outside; this block hands it one word per routed result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buffer_write <= 1'b0;
      buffer_channel <= 4'h0;
      buffered_result_high <= arw_pkg::ARW_RST_ZERO8;
      buffered_result_low <= arw_pkg::ARW_RST_ZERO8;
    end else begin
      buffer_write <= conv_done && dest == arw_pkg::ARW_DEST_BUFFER;
      if (conv_done && dest == arw_pkg::ARW_DEST_BUFFER) begin
        buffer_channel <= conv_channel;
        buffered_result_high <= {4'h0, conv_result[11:8]};
        buffered_result_low <= conv_result[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overrun detection

  logic overrun_r;
  logic overrun_set;
  logic unread_now;

  // unread state of the target store: direct register or the external buffer
  // a read of the lower part took the old word at its address phase, so a result
  // landing in that read's data phase overwrites nothing unread
  assign unread_now = (dest == arw_pkg::ARW_DEST_DIRECT) ? (unread_r && !rd_data) : buffer_read;
  assign overrun_set = conv_done && unread_now;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unread_r <= 1'b0;
    end else if (conv_done && dest == arw_pkg::ARW_DEST_DIRECT) begin
      unread_r <= 1'b1;
    end else if (rd_data) begin
      unread_r <= 1'b0;
    end
  end

  // set wins over a simultaneous software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_r <= 1'b0;
    end else if (overrun_set) begin
      overrun_r <= 1'b1;
    end else if (w_ctrl && !hwdata[arw_pkg::ARW_BIT_OVERRUN]) begin
      overrun_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog watchdog

  logic outside;
  logic wd_active;
  logic [arw_pkg::ARW_NCH-1:0] flags_r;
  logic [arw_pkg::ARW_NCH-1:0] enable_all;
  logic [arw_pkg::ARW_NCH-1:0] clr_mask;

  arw_watchdog_cmp u_cmp (
    .result(conv_result),
    .upper_limit({uh_r, ul_r}),
    .lower_limit({lh_r, ll_r}),
    .outside(outside)
  );

  assign wd_active = buffered || scan_r;
  assign enable_all = {en_u_r, en_l_r};
  // a zero written in a flag field clears that flag; ones leave it
  assign clr_mask = {w_fu ? ~hwdata[1:0] : 2'b00, w_fl ? ~hwdata[7:0] : 8'h00};

  // one flag per channel, set has priority over clear
  // a clear written in the same cycle as an event loses, so no event goes unseen
  genvar g;
  generate
    for (g = 0; g < arw_pkg::ARW_NCH; g = g + 1) begin : g_flag
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flags_r[g] <= 1'b0;
        end else if (conv_done && wd_active && outside && enable_all[g] &&
                     conv_channel == 4'(g)) begin
          flags_r[g] <= 1'b1;
        end else if (clr_mask[g]) begin
          flags_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read data, registered in the data phase

  // reserved bits read back as zero in every register
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (idx_nxt)
      arw_pkg::ARW_IDX_CTRL_THREE: begin
        rdata_nxt[arw_pkg::ARW_BIT_OVERRUN] = overrun_r;
        rdata_nxt[arw_pkg::ARW_BIT_BUFFER_EN] = buffer_en_r;
      end
      arw_pkg::ARW_IDX_RESULT_UPPER: rdata_nxt[7:0] = res_hi_r;
      arw_pkg::ARW_IDX_RESULT_LOWER: rdata_nxt[7:0] = res_lo_r;
      arw_pkg::ARW_IDX_SCHMITT_UPPER: rdata_nxt[7:0] = sch_u_r;
      arw_pkg::ARW_IDX_SCHMITT_LOWER: rdata_nxt[7:0] = sch_l_r;
      arw_pkg::ARW_IDX_WD_UPPER_HIGH: rdata_nxt[7:0] = uh_r;
      arw_pkg::ARW_IDX_WD_UPPER_LOW: rdata_nxt[3:0] = ul_r;
      arw_pkg::ARW_IDX_WD_LOWER_HIGH: rdata_nxt[7:0] = lh_r;
      arw_pkg::ARW_IDX_WD_LOWER_LOW: rdata_nxt[3:0] = ll_r;
      arw_pkg::ARW_IDX_WD_FLAGS_UPPER: rdata_nxt[1:0] = flags_r[9:8];
      arw_pkg::ARW_IDX_WD_FLAGS_LOWER: rdata_nxt[7:0] = flags_r[7:0];
      arw_pkg::ARW_IDX_WD_ENABLE_UPPER: rdata_nxt[1:0] = en_u_r;
      arw_pkg::ARW_IDX_WD_ENABLE_LOWER: rdata_nxt[7:0] = en_l_r;
      arw_pkg::ARW_IDX_MODE: begin
        rdata_nxt[arw_pkg::ARW_BIT_CONTINUOUS] = cont_r;
        rdata_nxt[arw_pkg::ARW_BIT_SCAN] = scan_r;
      end
      default: rdata_nxt = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  // sampled at the address phase, so reads reflect state before any same-cycle write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

endmodule

/* File: tb/arw_regs_assertions.sv */
// checker: port timing of the converter register block
`timescale 1ns/1ps
module arw_regs_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  input wire logic [3:0] conv_channel,
  input wire logic buffer_write,
  input wire logic [3:0] buffer_channel,
  input wire logic [7:0] buffered_result_high,
  input wire logic [7:0] buffered_result_low,
  input wire logic [15:0] schmitt_disable_bits,
  input wire logic continuous_mode_select,
  input wire logic scan_mode
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ph_r;
  logic wr_r;
  logic [7:0] idx_r;
  // remember the address phase so the data phase can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= 1'b0;
      wr_r <= 1'b0;
      idx_r <= 8'h00;
    end else if (hready) begin
      ph_r <= hsel & htrans[1];
      wr_r <= hwrite;
      idx_r <= haddr[9:2];
    end
  end
  wire logic wr_ph = ph_r & wr_r;
  wire logic rd_ph = ph_r & ~wr_r;
  wire logic sch_wr = wr_ph && (idx_r == arw_pkg::ARW_IDX_SCHMITT_LOWER ||
                                idx_r == arw_pkg::ARW_IDX_SCHMITT_UPPER);
  a_buffer_write_cause: assert property (buffer_write |-> $past(conv_done))
    else $error("buffer write without a conversion");
  a_single_no_buffer: assert property (conv_done && !continuous_mode_select
    |=> !buffer_write)
    else $error("single mode result went to the buffer");
  a_buffer_data_split: assert property (buffer_write |->
    buffered_result_low == $past(conv_result[7:0]) && buffer_channel == $past(conv_channel)
    && buffered_result_high == {4'h0, $past(conv_result[11:8])})
    else $error("buffered result split wrong");
  a_buffer_hold: assert property (!buffer_write |->
    $stable(buffered_result_low) && $stable(buffered_result_high))
    else $error("buffered result moved without a write");
  a_schmitt_lower_write: assert property (wr_ph &&
    idx_r == arw_pkg::ARW_IDX_SCHMITT_LOWER |=>
    schmitt_disable_bits[7:0] == $past(hwdata[7:0]) && $stable(schmitt_disable_bits[15:8]))
    else $error("lower schmitt write wrong");
  a_schmitt_hold: assert property (!sch_wr |=> $stable(schmitt_disable_bits))
    else $error("schmitt bits moved without a write");
  a_mode_write: assert property (wr_ph && idx_r == arw_pkg::ARW_IDX_MODE |=>
    continuous_mode_select == $past(hwdata[arw_pkg::ARW_BIT_CONTINUOUS]) &&
    scan_mode == $past(hwdata[arw_pkg::ARW_BIT_SCAN]))
    else $error("mode write wrong");
  a_result_read_pad: assert property (rd_ph &&
    (idx_r == arw_pkg::ARW_IDX_RESULT_UPPER || idx_r == arw_pkg::ARW_IDX_RESULT_LOWER)
    |-> hrdata[31:8] == 24'h0)
    else $error("result read has upper bits set");
  a_schmitt_readback: assert property (rd_ph &&
    idx_r == arw_pkg::ARW_IDX_SCHMITT_UPPER |->
    hrdata == {24'h0, $past(schmitt_disable_bits[15:8])})
    else $error("upper schmitt read wrong");
  c_buffered: cover property (buffer_write);
  c_schmitt_write: cover property (sch_wr);
  c_scan: cover property (conv_done && scan_mode);
endmodule
bind arw_regs arw_regs_checker u_arw_regs_checker (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .conv_done(conv_done),
  .conv_result(conv_result),
  .conv_channel(conv_channel),
  .buffer_write(buffer_write),
  .buffer_channel(buffer_channel),
  .buffered_result_high(buffered_result_high),
  .buffered_result_low(buffered_result_low),
  .schmitt_disable_bits(schmitt_disable_bits),
  .continuous_mode_select(continuous_mode_select),
  .scan_mode(scan_mode)
);

/* File: tb/test_adc_result_and_watchdog_regs.sv */
// testbench: bus, conversion and watchdog scenarios of the converter register block
`timescale 1ns/1ps
module test_adc_result_and_watchdog_regs;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic conv_done = 1'b0;
  logic [11:0] conv_result = 12'h0;
  logic [3:0] conv_channel = 4'h0;
  logic buffer_read = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, buffer_write, continuous_mode_select, scan_mode;
  logic [3:0] buffer_channel;
  logic [7:0] buffered_result_high, buffered_result_low;
  logic [15:0] schmitt_disable_bits;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  arw_regs u_arw_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .conv_done(conv_done),
    .conv_result(conv_result),
    .conv_channel(conv_channel),
    .buffer_read(buffer_read),
    .buffer_write(buffer_write),
    .buffer_channel(buffer_channel),
    .buffered_result_high(buffered_result_high),
    .buffered_result_low(buffered_result_low),
    .schmitt_disable_bits(schmitt_disable_bits),
    .continuous_mode_select(continuous_mode_select),
    .scan_mode(scan_mode)
  );
  initial forever #20 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one single transfer; the leading edge keeps an idle cycle between transfers
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= arw_pkg::ARW_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    #1; // let a data-phase write settle before any pin is compared
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    check(what, q, exp);
  endtask
  // one conversion pulse; returns once the result edge has landed
  task automatic conv(input logic [11:0] r, input logic [3:0] ch);
    @(posedge hclk);
    conv_done <= 1'b1;
    conv_result <= r;
    conv_channel <= ch;
    @(posedge hclk);
    conv_done <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    logic [7:0] ix [11] = '{arw_pkg::ARW_IDX_CTRL_THREE, arw_pkg::ARW_IDX_RESULT_UPPER,
      arw_pkg::ARW_IDX_RESULT_LOWER, arw_pkg::ARW_IDX_SCHMITT_UPPER,
      arw_pkg::ARW_IDX_SCHMITT_LOWER, arw_pkg::ARW_IDX_WD_UPPER_HIGH,
      arw_pkg::ARW_IDX_WD_UPPER_LOW, arw_pkg::ARW_IDX_WD_LOWER_HIGH,
      arw_pkg::ARW_IDX_WD_LOWER_LOW, arw_pkg::ARW_IDX_WD_FLAGS_UPPER, 8'h40};
    logic [31:0] rv [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hff, 32'hf,
      32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 11; i++) rdc("reset value", ix[i], rv[i]);
    check("schmitt pins", {16'h0, schmitt_disable_bits}, 32'h0);
    check("ready high", {31'h0, hreadyout}, 32'h1);
    check("okay response", {31'h0, hresp}, 32'h0);
    $display("test_reset done");
  endtask
  // the Schmitt and watchdog limit fields take ones and zeros; the read-only result ignores a write
  task automatic test_rw;
    logic [7:0] ix [7] = '{arw_pkg::ARW_IDX_SCHMITT_UPPER, arw_pkg::ARW_IDX_SCHMITT_LOWER,
      arw_pkg::ARW_IDX_WD_UPPER_HIGH, arw_pkg::ARW_IDX_WD_UPPER_LOW,
      arw_pkg::ARW_IDX_WD_LOWER_HIGH, arw_pkg::ARW_IDX_WD_LOWER_LOW,
      arw_pkg::ARW_IDX_RESULT_UPPER};
    logic [31:0] mk [7] = '{32'hff, 32'hff, 32'hff, 32'hf, 32'hff, 32'hf, 32'h0};
    for (int i = 0; i < 7; i++) wr(ix[i], 32'hffffffff);
    for (int i = 0; i < 7; i++) rdc("ones read", ix[i], mk[i]);
    check("schmitt pins", {16'h0, schmitt_disable_bits}, 32'hffff);
    for (int i = 0; i < 7; i++) wr(ix[i], 32'h0);
    for (int i = 0; i < 7; i++) rdc("zeros read", ix[i], 32'h0);
    $display("test_rw done");
  endtask
  task automatic test_direct;
    conv(12'hab5, 4'h3);
    check("no buffer in single", {31'h0, buffer_write}, 32'h0);
    rdc("result upper", arw_pkg::ARW_IDX_RESULT_UPPER, 32'h0a);
    rdc("result lower", arw_pkg::ARW_IDX_RESULT_LOWER, 32'hb5);
    conv(12'h123, 4'h1);
    conv(12'h456, 4'h2);
    rdc("overrun set", arw_pkg::ARW_IDX_CTRL_THREE, 32'h40);
    rdc("newest lower", arw_pkg::ARW_IDX_RESULT_LOWER, 32'h56);
    wr(arw_pkg::ARW_IDX_CTRL_THREE, 32'h40);
    rdc("overrun kept", arw_pkg::ARW_IDX_CTRL_THREE, 32'h40);
    wr(arw_pkg::ARW_IDX_CTRL_THREE, 32'h0);
    rdc("overrun cleared", arw_pkg::ARW_IDX_CTRL_THREE, 32'h0);
    $display("test_direct done");
  endtask
  task automatic test_buffered;
    wr(arw_pkg::ARW_IDX_CTRL_THREE, 32'h80);
    wr(arw_pkg::ARW_IDX_MODE, 32'h1);
    check("continuous pin", {31'h0, continuous_mode_select}, 32'h1);
    conv(12'h3c7, 4'h5);
    check("buffer pulse", {31'h0, buffer_write}, 32'h1);
    check("buffer data", {12'h0, buffer_channel, buffered_result_high,
      buffered_result_low}, 32'h503c7);
    rdc("direct untouched", arw_pkg::ARW_IDX_RESULT_LOWER, 32'h56);
    buffer_read <= 1'b1;
    conv(12'h111, 4'h6);
    buffer_read <= 1'b0;
    rdc("buffer overrun", arw_pkg::ARW_IDX_CTRL_THREE, 32'hc0);
    wr(arw_pkg::ARW_IDX_CTRL_THREE, 32'h80);
    rdc("overrun cleared", arw_pkg::ARW_IDX_CTRL_THREE, 32'h80);
    $display("test_buffered done");
  endtask
  // window 0x100..0x800, only channels 9 and 0 watched
  task automatic test_watchdog;
    wr(arw_pkg::ARW_IDX_WD_UPPER_HIGH, 32'h80);
    wr(arw_pkg::ARW_IDX_WD_LOWER_HIGH, 32'h10);
    wr(arw_pkg::ARW_IDX_WD_ENABLE_UPPER, 32'h2);
    wr(arw_pkg::ARW_IDX_WD_ENABLE_LOWER, 32'h1);
    conv(12'h801, 4'h9);
    conv(12'hfff, 4'h8);
    conv(12'h0ff, 4'h0);
    rdc("flags upper", arw_pkg::ARW_IDX_WD_FLAGS_UPPER, 32'h2);
    rdc("flags lower", arw_pkg::ARW_IDX_WD_FLAGS_LOWER, 32'h1);
    wr(arw_pkg::ARW_IDX_WD_FLAGS_UPPER, 32'h3);
    rdc("flags one kept", arw_pkg::ARW_IDX_WD_FLAGS_UPPER, 32'h2);
    wr(arw_pkg::ARW_IDX_WD_FLAGS_UPPER, 32'h0);
    wr(arw_pkg::ARW_IDX_WD_FLAGS_LOWER, 32'h0);
    conv(12'h800, 4'h9);
    conv(12'h100, 4'h0);
    rdc("edge upper clear", arw_pkg::ARW_IDX_WD_FLAGS_UPPER, 32'h0);
    rdc("edge lower clear", arw_pkg::ARW_IDX_WD_FLAGS_LOWER, 32'h0);
    wr(arw_pkg::ARW_IDX_CTRL_THREE, 32'h0);
    conv(12'hfff, 4'h9);
    rdc("unbuffered no flag", arw_pkg::ARW_IDX_WD_FLAGS_UPPER, 32'h0);
    wr(arw_pkg::ARW_IDX_MODE, 32'h2);
    check("scan pin", {31'h0, scan_mode}, 32'h1);
    conv(12'hfff, 4'h9);
    rdc("scan flag", arw_pkg::ARW_IDX_WD_FLAGS_UPPER, 32'h2);
    $display("test_watchdog done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // a hang counts as a failure and ends the run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      report_and_stop;
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset;
    test_rw;
    test_direct;
    test_buffered;
    test_watchdog;
    report_and_stop;
  end
endmodule
